// ### hdl/mhg_dev.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - reset: all io lines input, weak pull-down
// - software sets direction and pull strength per line; only lines one to eight have an index, the ninth line has none
// - handshake lines low means asserted
// - serial data lines idle high
// - ring low when remote starts connection
// - carrier low while connection live
// - host drives data-set-ready from its terminal-ready
// - high-speed mode: host holds data-set-ready asserted
// - high-speed: data-set-ready drop ends or pauses link
// - io lines via indices 621 to 628
// - led lit when line four is one
// - input line four: host drives led
// - line three as terminal-ready, indices 552/553
// - analogue values at indices 701 and 702
// - each analogue channel eight bits
// - ring and carrier direction programmable
module mhg_dev #(
  parameter int unsigned NUM_IO = mhg_pkg::NUM_IO
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  mhg_if.dev                               lnk,
  input  wire logic                        remote_connect,
  input  wire logic                        remote_drop,
  input  wire logic [mhg_pkg::ANA_W-1:0]   analogue_channel_zero,
  input  wire logic [mhg_pkg::ANA_W-1:0]   analogue_channel_one,
  output logic                             led_on,
  output logic                             link_live,
  output logic                             online_cmd_mode,
  output logic [NUM_IO-1:0]                io_sampled
);
  // ==========================================================================
  // state
  typedef struct packed {
    logic [NUM_IO-1:0][3:0] io;
    logic                   hs_mode;
    logic                   dtr_en;
    logic                   dtr_pol;
    logic [1:0]             hs_dir;   // [0] ring out, [1] carrier out
    mhg_pkg::mhg_conn_e     conn;
    logic                   dsr_seen;
    logic [31:0]            rdata;
    logic                   ack;
    logic [NUM_IO-1:0]      samp;
  } mhg_dev_s;
  mhg_dev_s s_q, s_d;
  logic dsr_asserted;
  assign dsr_asserted = ~lnk.dsr_n;

  always_comb begin
    s_d      = s_q;
    s_d.ack  = 1'b0;
    s_d.samp = lnk.io_level;
    // connection state
    case (s_q.conn)
      mhg_pkg::MHG_IDLE: begin
        if (remote_connect) s_d.conn = mhg_pkg::MHG_RING;
        else if (lnk.connect_req) s_d.conn = mhg_pkg::MHG_LIVE;
      end
      mhg_pkg::MHG_RING: begin
        s_d.conn = mhg_pkg::MHG_LIVE;
      end
      mhg_pkg::MHG_LIVE: begin
        if (s_q.hs_mode && s_q.dsr_seen && !dsr_asserted) begin
          // deassert with a pending connect request means command mode
          s_d.conn = lnk.connect_req ? mhg_pkg::MHG_CMD : mhg_pkg::MHG_IDLE;
        end
      end
      mhg_pkg::MHG_CMD: begin
        if (dsr_asserted) s_d.conn = mhg_pkg::MHG_LIVE;
        else if (!lnk.connect_req) s_d.conn = mhg_pkg::MHG_IDLE;
      end
      default: s_d.conn = mhg_pkg::MHG_IDLE;
    endcase
    if (remote_drop) s_d.conn = mhg_pkg::MHG_IDLE;
    s_d.dsr_seen = dsr_asserted;
    // config index access
    if (lnk.cfg_req && !s_q.ack) begin
      s_d.ack   = 1'b1;
      s_d.rdata = mhg_pkg::RD_ZERO;
      if (lnk.cfg_idx >= mhg_pkg::IDX_IO_FIRST && lnk.cfg_idx <= mhg_pkg::IDX_IO_LAST) begin
        for (int i = 0; i < NUM_IO - 1; i++) begin
          if (lnk.cfg_idx == mhg_pkg::IDX_IO_FIRST + 10'(i)) begin
            if (lnk.cfg_we) s_d.io[i] = lnk.cfg_wdata[3:0];
            s_d.rdata = {27'h000_0000, lnk.io_level[i], s_q.io[i]};
          end
        end
      end else begin
        case (lnk.cfg_idx)
          mhg_pkg::IDX_HS_MODE: begin
            if (lnk.cfg_we) s_d.hs_mode = lnk.cfg_wdata[0];
            s_d.rdata = {31'h0000_0000, s_q.hs_mode};
          end
          mhg_pkg::IDX_DTR_EN: begin
            if (lnk.cfg_we) s_d.dtr_en = lnk.cfg_wdata[0];
            s_d.rdata = {31'h0000_0000, s_q.dtr_en};
          end
          mhg_pkg::IDX_DTR_POL: begin
            if (lnk.cfg_we) s_d.dtr_pol = lnk.cfg_wdata[0];
            s_d.rdata = {31'h0000_0000, s_q.dtr_pol};
          end
          mhg_pkg::IDX_HS_DIR: begin
            if (lnk.cfg_we) s_d.hs_dir = lnk.cfg_wdata[1:0];
            s_d.rdata = {30'h0000_0000, s_q.hs_dir};
          end
          mhg_pkg::IDX_ANA0: s_d.rdata = {24'h00_0000, analogue_channel_zero};
          mhg_pkg::IDX_ANA1: s_d.rdata = {24'h00_0000, analogue_channel_one};
          default: s_d.rdata = mhg_pkg::RD_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q          <= '0;  // every line input with weak pull-down
      s_q.hs_dir   <= 2'b11;
      s_q.conn     <= mhg_pkg::MHG_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // pins
  logic conn_live;
  assign conn_live = (s_q.conn == mhg_pkg::MHG_LIVE) || (s_q.conn == mhg_pkg::MHG_CMD);
  assign lnk.ring_indicate_line_o   = ~(s_q.conn == mhg_pkg::MHG_RING);
  assign lnk.ring_indicate_line_oe  = s_q.hs_dir[0];
  assign lnk.carrier_detect_line_o  = ~conn_live;
  assign lnk.carrier_detect_line_oe = s_q.hs_dir[1];
  assign lnk.txd       = 1'b1;  // no data path here, idle high
  assign lnk.cfg_rdata = s_q.rdata;
  assign lnk.cfg_ack   = s_q.ack;

  genvar g;
  for (g = 0; g < NUM_IO; g++) begin : g_io
    if (g == mhg_pkg::DTR_LINE) begin : g_dtr
      // terminal-ready out, active low while dtr_pol is clear: low while connection live
      assign lnk.io_dev_o[g]  = s_q.dtr_en ? (conn_live ^ ~s_q.dtr_pol) : s_q.io[g][mhg_pkg::F_VAL];
      assign lnk.io_dev_oe[g] = s_q.dtr_en | s_q.io[g][mhg_pkg::F_DIR];
    end else begin : g_gp
      assign lnk.io_dev_o[g]  = s_q.io[g][mhg_pkg::F_VAL];
      assign lnk.io_dev_oe[g] = s_q.io[g][mhg_pkg::F_DIR];
    end
    assign lnk.io_pull[g] = s_q.io[g][mhg_pkg::F_PUP];
  end

  assign led_on          = s_q.samp[mhg_pkg::LED_LINE];
  assign link_live       = conn_live;
  assign online_cmd_mode = (s_q.conn == mhg_pkg::MHG_CMD);
  assign io_sampled      = s_q.samp;
endmodule : mhg_dev
`default_nettype wire

// ### hdl/mhg_pkg.sv
package mhg_pkg;
  // ==========================================================================
  // widths and counts
  localparam int unsigned NUM_IO     = 9;
  localparam int unsigned ANA_W      = 8;
  localparam int unsigned IDX_W      = 10;
  // ==========================================================================
  // configuration indices
  localparam logic [9:0] IDX_HS_MODE   = 10'h1_FB;  // 507
  localparam logic [9:0] IDX_DTR_EN    = 10'h2_28;  // 552
  localparam logic [9:0] IDX_DTR_POL   = 10'h2_29;  // 553
  localparam logic [9:0] IDX_IO_FIRST  = 10'h2_6D;  // 621
  localparam logic [9:0] IDX_IO_LAST   = 10'h2_74;  // 628
  localparam logic [9:0] IDX_ANA0      = 10'h2_BD;  // 701
  localparam logic [9:0] IDX_ANA1      = 10'h2_BE;  // 702
  localparam logic [9:0] IDX_HS_DIR    = 10'h2_C6;  // 710, ring/carrier direction
  // ==========================================================================
  // io line entry: [0] out value, [1] dir out, [2] pull up, [3] strong pull
  localparam int unsigned F_VAL    = 0;
  localparam int unsigned F_DIR    = 1;
  localparam int unsigned F_PUP    = 2;
  localparam int unsigned F_STRONG = 3;
  localparam logic [3:0]  IO_RESET = 4'h0;  // input, weak pull-down
  localparam int unsigned LED_LINE = 3;     // line four, index from zero
  localparam int unsigned DTR_LINE = 2;     // line three
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
  // ==========================================================================
  // host AHB register offsets
  localparam logic [7:0] A_CTRL   = 8'h00;  // [0] connect req, [1] dtr
  localparam logic [7:0] A_IDX    = 8'h04;
  localparam logic [7:0] A_WDATA  = 8'h08;  // write starts a config write
  localparam logic [7:0] A_RDATA  = 8'h0C;  // write starts a config read
  localparam logic [7:0] A_STATUS = 8'h10;  // [0] ring, [1] carrier, [2] dropped
  typedef enum logic [1:0] {
    MHG_IDLE   = 2'b00,
    MHG_RING   = 2'b01,
    MHG_LIVE   = 2'b11,
    MHG_CMD    = 2'b10
  } mhg_conn_e;
endpackage : mhg_pkg

// ### hdl/mhg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mhg_if;
  // handshake lines are active low
  logic                         ring_indicate_line_o;
  logic                         ring_indicate_line_oe;
  logic                         ring_indicate_line_i;
  logic                         carrier_detect_line_o;
  logic                         carrier_detect_line_oe;
  logic                         carrier_detect_line_i;
  logic                         dsr_n;
  logic                         txd;
  logic                         rxd;
  logic [mhg_pkg::NUM_IO-1:0]   io_dev_o;
  logic [mhg_pkg::NUM_IO-1:0]   io_dev_oe;
  logic [mhg_pkg::NUM_IO-1:0]   io_host_o;
  logic [mhg_pkg::NUM_IO-1:0]   io_host_oe;
  logic [mhg_pkg::NUM_IO-1:0]   io_pull;
  // wire level: OR of device and host drives, pull only when neither drives
  wire  [mhg_pkg::NUM_IO-1:0]   io_level = (io_dev_o & io_dev_oe) | (io_host_o & io_host_oe)
                                          | (io_pull & ~io_dev_oe & ~io_host_oe);
  // config index access
  logic                         cfg_req;
  logic                         cfg_we;
  logic [mhg_pkg::IDX_W-1:0]    cfg_idx;
  logic [31:0]                  cfg_wdata;
  logic [31:0]                  cfg_rdata;
  logic                         cfg_ack;
  logic                         connect_req;
  modport dev  (output ring_indicate_line_o, ring_indicate_line_oe, carrier_detect_line_o,
                carrier_detect_line_oe, txd, io_dev_o, io_dev_oe, io_pull, cfg_rdata, cfg_ack,
                input ring_indicate_line_i, carrier_detect_line_i, dsr_n, rxd, io_level,
                cfg_req, cfg_we, cfg_idx, cfg_wdata, connect_req);
  modport host (input ring_indicate_line_o, carrier_detect_line_o, txd, io_level, cfg_rdata, cfg_ack,
                output ring_indicate_line_i, carrier_detect_line_i, dsr_n, rxd, io_host_o, io_host_oe,
                cfg_req, cfg_we, cfg_idx, cfg_wdata, connect_req);
endinterface : mhg_if
`default_nettype wire

// ### hdl/mhg_host.sv
`timescale 1ns/100ps
`default_nettype none
module mhg_host (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic [8:0]    io_drive,
  input  wire logic [8:0]    io_drive_en,
  mhg_if.host                lnk
);
  typedef struct packed {
    logic        pend;
    logic        pwr;
    logic [7:0]  paddr;
    logic        conn;
    logic        dtr;      // terminal-ready asserted
    logic [9:0]  idx;
    logic [31:0] wd;
    logic [31:0] rd;
    logic        busy;
    logic        bwe;
    logic        dropped;
    logic        was_live;
    logic [31:0] hrd;
  } mhg_host_s;
  mhg_host_s s_q, s_d;
  logic      live;
  assign live = ~lnk.carrier_detect_line_o;

  // ==========================================================================
  // AHB slave: write data arrives in data phase; cfg ops stall with hreadyout
  always_comb begin
    s_d          = s_q;
    s_d.was_live = live;
    if (s_q.was_live && !live) s_d.dropped = 1'b1;
    if (s_q.busy && lnk.cfg_ack) begin
      s_d.busy = 1'b0;
      s_d.rd   = lnk.cfg_rdata;
    end
    if (s_q.pend && !s_q.busy) begin
      s_d.pend = 1'b0;
      if (s_q.pwr) begin
        case (s_q.paddr)
          mhg_pkg::A_CTRL: begin
            s_d.conn = hwdata[0];
            s_d.dtr  = hwdata[1];
          end
          mhg_pkg::A_IDX:   s_d.idx = hwdata[9:0];
          mhg_pkg::A_WDATA: begin
            s_d.wd   = hwdata;
            s_d.busy = 1'b1;
            s_d.bwe  = 1'b1;
          end
          mhg_pkg::A_RDATA: begin
            s_d.busy = 1'b1;
            s_d.bwe  = 1'b0;
          end
          mhg_pkg::A_STATUS: if (hwdata[2]) s_d.dropped = 1'b0;
          default: ;
        endcase
      end
    end
    if (hsel && htrans[1] && hready && hreadyout) begin
      s_d.pend  = 1'b1;
      s_d.pwr   = hwrite;
      s_d.paddr = haddr[7:0];
      case (haddr[7:0])
        mhg_pkg::A_CTRL:   s_d.hrd = {30'h0000_0000, s_q.dtr, s_q.conn};
        mhg_pkg::A_IDX:    s_d.hrd = {22'h00_0000, s_q.idx};
        mhg_pkg::A_WDATA:  s_d.hrd = s_q.wd;
        mhg_pkg::A_RDATA:  s_d.hrd = s_q.rd;
        mhg_pkg::A_STATUS: s_d.hrd = {29'h0000_0000, s_q.dropped, live, ~lnk.ring_indicate_line_o};
        default:           s_d.hrd = mhg_pkg::RD_ZERO;
      endcase
    end
    if (s_q.was_live && !live) s_d.dropped = 1'b1;  // set wins over clear
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) s_q <= '0;
    else s_q <= s_d;
  end

  // stall a data phase while a config op is outstanding
  assign hreadyout = ~(s_q.pend & s_q.busy) & ~(s_q.busy & s_q.pend);
  assign hrdata    = (s_q.paddr == mhg_pkg::A_RDATA) ? s_q.rd : s_q.hrd;
  assign hresp     = 1'b0;

  assign lnk.dsr_n                 = ~s_q.dtr;
  assign lnk.rxd                   = 1'b1;
  assign lnk.ring_indicate_line_i  = 1'b1;
  assign lnk.carrier_detect_line_i = 1'b1;
  assign lnk.io_host_o             = io_drive;
  assign lnk.io_host_oe            = io_drive_en;
  assign lnk.cfg_req               = s_q.busy & ~lnk.cfg_ack;
  assign lnk.cfg_we                = s_q.bwe;
  assign lnk.cfg_idx               = s_q.idx;
  assign lnk.cfg_wdata             = s_q.wd;
  assign lnk.connect_req           = s_q.conn;
endmodule : mhg_host
`default_nettype wire

// ### test/mhg_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module mhg_asserts (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       ring_indicate_line_o,
  input wire logic                       ring_indicate_line_oe,
  input wire logic                       carrier_detect_line_o,
  input wire logic                       carrier_detect_line_oe,
  input wire logic                       dsr_n,
  input wire logic                       txd,
  input wire logic [mhg_pkg::NUM_IO-1:0] io_dev_oe,
  input wire logic [mhg_pkg::NUM_IO-1:0] io_pull,
  input wire logic                       cfg_req,
  input wire logic                       cfg_we,
  input wire logic [mhg_pkg::IDX_W-1:0]  cfg_idx,
  input wire logic [31:0]                cfg_wdata,
  input wire logic                       cfg_ack,
  input wire logic                       connect_req
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic hs_q;
  // ==========================================================================
  // mirror of the high-speed setting, taken from completed config writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_q <= 1'b0;
    end else if (cfg_req && cfg_we && !cfg_ack && cfg_idx == mhg_pkg::IDX_HS_MODE) begin
      hs_q <= cfg_wdata[0];
    end
  end
  // ==========================================================================
  // assertions
  a_reset_io_input: assert property ($rose(hresetn) |-> io_dev_oe == '0 && io_pull == '0)
    else $error("io lines not input with pull-down after reset");
  a_reset_lines_out: assert property ($rose(hresetn) |-> ring_indicate_line_oe && carrier_detect_line_oe
    && ring_indicate_line_o && carrier_detect_line_o) else $error("handshake lines wrong after reset");
  a_txd_idle_high: assert property (txd)
    else $error("transmit line not idle high");
  a_cfg_answer: assert property (cfg_req && !cfg_ack |=> cfg_ack)
    else $error("config request not answered next cycle");
  a_ack_one_pulse: assert property (cfg_ack |=> !cfg_ack)
    else $error("config ack longer than one cycle");
  a_connect_live: assert property ($rose(connect_req) && carrier_detect_line_o
    |-> ##[1:2] !carrier_detect_line_o) else $error("carrier not asserted after connect");
  a_ring_then_live: assert property ($fell(ring_indicate_line_o) |-> ##[0:2] !carrier_detect_line_o)
    else $error("ring asserted without connection following");
  a_drop_both_high: assert property ($rose(carrier_detect_line_o) |-> ring_indicate_line_o)
    else $error("ring still asserted when carrier released");
  a_dsr_drop: assert property (hs_q && $rose(dsr_n) && !carrier_detect_line_o && !connect_req
    |-> ##[1:2] carrier_detect_line_o) else $error("link kept after ready released");
  a_dsr_cmd_hold: assert property (hs_q && $rose(dsr_n) && !carrier_detect_line_o && connect_req
    |=> !carrier_detect_line_o [*2]) else $error("carrier lost on command mode entry");
  c_remote_ring: cover property ($fell(ring_indicate_line_o));
  c_hs_drop: cover property (hs_q && $rose(dsr_n) && !connect_req);
  c_cmd_mode: cover property (hs_q && $rose(dsr_n) && connect_req);
endmodule : mhg_asserts
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {logic [9:0] idx; logic we; logic [7:0] wd; logic [7:0] ex;} mhg_row_s;
  // eight io rows, then two analogue rows: value, direction, pull-up, strong; read bit 4 is the line level
  localparam mhg_row_s ROWS [10] = '{'{10'h26D, 1'b1, 8'h03, 8'h13}, '{10'h26E, 1'b1, 8'h02, 8'h02},
    '{10'h26F, 1'b1, 8'h04, 8'h14}, '{10'h270, 1'b1, 8'h03, 8'h13}, '{10'h271, 1'b1, 8'h0C, 8'h1C},
    '{10'h272, 1'b1, 8'h08, 8'h08}, '{10'h273, 1'b1, 8'h01, 8'h01}, '{10'h274, 1'b1, 8'h0B, 8'h1B},
    '{10'h2BD, 1'b0, 8'h00, 8'hA5}, '{10'h2BE, 1'b0, 8'h00, 8'h3C}};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, remote_connect, remote_drop;
  logic led_on, link_live, online_cmd_mode;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [8:0] io_drive, io_drive_en, io_sampled;
  logic [7:0] analogue_channel_zero, analogue_channel_one;
  int num_errors, total_checks;
  mhg_if lnk ();
  mhg_dev i_mhg_dev (.hclk, .hresetn, .lnk, .remote_connect, .remote_drop, .analogue_channel_zero,
    .analogue_channel_one, .led_on, .link_live, .online_cmd_mode, .io_sampled);
  mhg_host i_mhg_host (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .io_drive, .io_drive_en, .lnk);
  mhg_asserts i_mhg_asserts (.hclk, .hresetn, .ring_indicate_line_o(lnk.ring_indicate_line_o),
    .ring_indicate_line_oe(lnk.ring_indicate_line_oe), .carrier_detect_line_o(lnk.carrier_detect_line_o),
    .carrier_detect_line_oe(lnk.carrier_detect_line_oe), .dsr_n(lnk.dsr_n), .txd(lnk.txd),
    .io_dev_oe(lnk.io_dev_oe), .io_pull(lnk.io_pull), .cfg_req(lnk.cfg_req), .cfg_we(lnk.cfg_we),
    .cfg_idx(lnk.cfg_idx), .cfg_wdata(lnk.cfg_wdata), .cfg_ack(lnk.cfg_ack), .connect_req(lnk.connect_req));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ==========================================================================
  // tasks
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // bounded wait for hreadyout sampled high at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 200) begin
        num_errors++;
        complete_run();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    hsize <= 3'b010;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : ahb
  task automatic cfg_wr(input logic [9:0] i, input logic [31:0] v);
    ahb(1'b1, mhg_pkg::A_IDX, {22'h00_0000, i});
    ahb(1'b1, mhg_pkg::A_WDATA, v);
    // this data phase stalls until the config write has landed
    ahb(1'b0, mhg_pkg::A_IDX, mhg_pkg::RD_ZERO);
  endtask : cfg_wr
  task automatic cfg_rd(input logic [9:0] i);
    ahb(1'b1, mhg_pkg::A_IDX, {22'h00_0000, i});
    ahb(1'b1, mhg_pkg::A_RDATA, mhg_pkg::RD_ZERO);
    ahb(1'b0, mhg_pkg::A_RDATA, mhg_pkg::RD_ZERO);
  endtask : cfg_rd
  task automatic reset_check;
    check(32'({lnk.io_dev_oe, lnk.io_pull}), 32'h0000_0000);
    check(32'({lnk.ring_indicate_line_o, lnk.carrier_detect_line_o}), 32'h0000_0003);
    check(32'({hresp, io_sampled}), 32'h0000_0000);
    cfg_rd(mhg_pkg::IDX_IO_FIRST);
    check(rd, 32'h0000_0000);
  endtask : reset_check
  // ==========================================================================
  // main sequence
  initial begin
    {hresetn, hsel, hwrite, remote_connect, remote_drop, htrans, hsize} = '0;
    {haddr, hwdata, io_drive, io_drive_en} = '0;
    analogue_channel_zero = 8'hA5;
    analogue_channel_one = 8'h3C;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_check();
    foreach (ROWS[k]) begin
      if (ROWS[k].we) cfg_wr(ROWS[k].idx, {24'h00_0000, ROWS[k].wd});
      cfg_rd(ROWS[k].idx);
      check(rd, {24'h00_0000, ROWS[k].ex});
    end
    check(32'(led_on), 32'h0000_0001);
    cfg_wr(10'h270, 32'h0000_0000);
    io_drive <= 9'h1FF;
    io_drive_en <= 9'h008;
    repeat (3) @(posedge hclk);
    check(32'(led_on), 32'h0000_0001);
    io_drive_en <= 9'h000;
    repeat (3) @(posedge hclk);
    check(32'(led_on), 32'h0000_0000);
    // unmapped offset: write ignored, read zero
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h20, mhg_pkg::RD_ZERO);
    check(rd, 32'h0000_0000);
    cfg_wr(mhg_pkg::IDX_HS_DIR, 32'h0000_0000);
    check(32'({lnk.ring_indicate_line_oe, lnk.carrier_detect_line_oe}), 32'h0000_0000);
    cfg_wr(mhg_pkg::IDX_HS_DIR, 32'h0000_0003);
    check(32'({lnk.ring_indicate_line_oe, lnk.carrier_detect_line_oe}), 32'h0000_0003);
    // remote connection with line three as terminal-ready
    cfg_wr(mhg_pkg::IDX_DTR_EN, 32'h0000_0001);
    remote_connect <= 1'b1;
    @(posedge hclk);
    remote_connect <= 1'b0;
    repeat (4) @(posedge hclk);
    check(32'({lnk.carrier_detect_line_o, link_live, lnk.io_level[2]}), 32'h0000_0002);
    ahb(1'b0, mhg_pkg::A_STATUS, mhg_pkg::RD_ZERO);
    check(rd, 32'h0000_0002);
    remote_drop <= 1'b1;
    @(posedge hclk);
    remote_drop <= 1'b0;
    repeat (2) @(posedge hclk);
    check(32'({lnk.ring_indicate_line_o, lnk.carrier_detect_line_o, lnk.io_level[2]}), 32'h0000_0007);
    ahb(1'b0, mhg_pkg::A_STATUS, mhg_pkg::RD_ZERO);
    check(32'(rd[2]), 32'h0000_0001);
    ahb(1'b1, mhg_pkg::A_STATUS, 32'h0000_0004);
    ahb(1'b0, mhg_pkg::A_STATUS, mhg_pkg::RD_ZERO);
    check(32'(rd[2]), 32'h0000_0000);
    // high-speed mode: ready released drops link, or enters command mode
    cfg_wr(mhg_pkg::IDX_HS_MODE, 32'h0000_0001);
    ahb(1'b1, mhg_pkg::A_CTRL, 32'h0000_0002);
    remote_connect <= 1'b1;
    @(posedge hclk);
    remote_connect <= 1'b0;
    repeat (4) @(posedge hclk);
    check(32'(lnk.carrier_detect_line_o), 32'h0000_0000);
    ahb(1'b1, mhg_pkg::A_CTRL, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    check(32'({lnk.carrier_detect_line_o, link_live}), 32'h0000_0002);
    ahb(1'b1, mhg_pkg::A_CTRL, 32'h0000_0003);
    repeat (3) @(posedge hclk);
    check(32'(lnk.carrier_detect_line_o), 32'h0000_0000);
    ahb(1'b1, mhg_pkg::A_CTRL, 32'h0000_0001);
    repeat (3) @(posedge hclk);
    check(32'({online_cmd_mode, lnk.carrier_detect_line_o}), 32'h0000_0002);
    ahb(1'b1, mhg_pkg::A_CTRL, 32'h0000_0003);
    repeat (3) @(posedge hclk);
    check(32'({online_cmd_mode, link_live}), 32'h0000_0001);
    // second reset while the link is live
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(32'(link_live), 32'h0000_0000);
    reset_check();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
